// [verilog/amz_defines.vh]
// constants for the audio mute and pwm zeroing block
`ifndef AMZ_DEFINES_VH
`define AMZ_DEFINES_VH
// register indices as printed; byte address is four times the index
`define AMZ_IDX_MUTE_CTRL 8'h18
`define AMZ_IDX_PWM_STAT 8'h19
`define AMZ_ADDR_MUTE_CTRL 12'h060
`define AMZ_ADDR_PWM_STAT 12'h064
// reset values
`define AMZ_RST_LATENCY 8'h7F
`define AMZ_RST_MUTE_CTRL 16'h7F00
// field positions in the mute control register
`define AMZ_F_LAT_HI 15
`define AMZ_F_LAT_LO 8
`define AMZ_F_ZERO_EN 5
`define AMZ_F_CLR_SEL 4
`define AMZ_F_SW_MUTE 3
`define AMZ_F_CLR_MUTE 2
`define AMZ_F_MUTE_STAT 1
`define AMZ_F_MUTE_FLAG 0
// latency step of 1.066 ms expressed in ns, and core clock period in ns
`define AMZ_STEP_NS 1066000
`define AMZ_CLK_NS 4
`define AMZ_STEP_CYC (`AMZ_STEP_NS / `AMZ_CLK_NS)
// half period of the idle square wave in clock cycles
`define AMZ_SQ_HALF 16
// mute ramp time in clock cycles
`define AMZ_RAMP_CYC 64
`endif

// [verilog/amz_sync.v]
// three-stage synchroniser with agreement filter for the mute pin
`timescale 1ns/1ps
`default_nettype none
module amz_sync
(
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // asynchronous level in, filtered level out
    input wire i_async,
    output reg o_level
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // --------------------------------------------------------------
    // stage chain
    // --------------------------------------------------------------
    // only s2 reads s1; the filter looks at s2 and s3 alone
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            o_level <= 1'b0;
        end
        else
        begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                o_level <= s3_q;
        end
    end
endmodule
`default_nettype wire

// [verilog/amz_mute_ctrl.v]
// mute control, pwm zeroing and apb register slave
//
// Behaviour
// - latency code sets 1.066 ms steps to zeroing
// - zero enable bit chooses zeroed or square wave
// - select 0: pin rising edge clears pin mute
// - select 1: pin mute held until clear bit
// - software mute bit mutes and unmutes
// - clear bit releases pin mute under select 1, self clears
// - status bit shows muting or muted
// - flag bit shows fully muted only
// - per channel bit set on leaving zero
`timescale 1ns/1ps
`default_nettype none
`include "amz_defines.vh"
module amz_mute_ctrl
#(
    parameter NCH = 4,
    parameter STEP_CYC = `AMZ_STEP_CYC
)
(
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // apb slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    // external mute pin, low means mute
    input wire i_mute_pin_n,
    // pwm stage: per channel audio request and output pins
    input wire [NCH-1:0] i_pwm_audio,
    output reg [NCH-1:0] o_amp_out,
    output reg o_muted
);
    // mute sequencer states
    localparam ST_RUN = 2'b00;
    localparam ST_MUTING = 2'b01;
    localparam ST_MUTED = 2'b10;
    localparam ST_UNMUTING = 2'b11;

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    // control register fields
    reg [7:0] lat_q;
    reg zero_en_q;
    reg clr_sel_q;
    reg sw_mute_q;
    reg clr_mute_q;
    // pin mute latch and the pin level one clock back
    reg pin_mute_q;
    reg pin_lvl_q;
    // mute sequencer, ramp and zeroing latency counters
    reg [1:0] st_q;
    reg [6:0] ramp_q;
    reg [31:0] step_q;
    reg [7:0] lat_cnt_q;
    reg zeroed_q;
    // idle square wave and per channel status
    reg [4:0] sq_cnt_q;
    reg sq_q;
    reg [NCH-1:0] ch_en_q;
    reg [NCH-1:0] prev_zero_q;
    // decodes, strobes and pin edges
    wire mute_stat;
    wire mute_flag;
    wire pin_lvl;
    wire mute_req;
    wire wr;
    wire rd;
    wire hit_ctrl;
    wire hit_stat;
    wire pin_rise;
    wire pin_fall;

    // ------------------------------------------------------------------
    // address decode, used by read and write paths
    // ------------------------------------------------------------------
    function dec;
        input [11:0] addr;
        input [11:0] target;
        begin
            dec = (addr == target);
        end
    endfunction

    assign hit_ctrl = dec(i_paddr, `AMZ_ADDR_MUTE_CTRL);
    assign hit_stat = dec(i_paddr, `AMZ_ADDR_PWM_STAT);
    // single wait-free access: setup then access with pready high
    // an unmapped address hits neither register, so its write changes nothing
    assign wr = i_psel & i_penable & i_pwrite & o_pready;
    assign rd = i_psel & i_penable & ~i_pwrite & o_pready;

    // ------------------------------------------------------------------
    // mute pin synchroniser
    // ------------------------------------------------------------------
    amz_sync u_sync
    (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(~i_mute_pin_n),
        .o_level(pin_lvl)
    );

    // the synchroniser resets to the idle level, so no false edge follows reset
    assign pin_fall = pin_lvl & ~pin_lvl_q;
    // pin released: its mute level falls, which is the pin's rising edge
    assign pin_rise = ~pin_lvl & pin_lvl_q;
    assign mute_req = sw_mute_q | pin_mute_q;

    // status covers the whole ramp down; the flag waits for its end
    assign mute_stat = (st_q == ST_MUTING) || (st_q == ST_MUTED);
    assign mute_flag = (st_q == ST_MUTED);

    // ------------------------------------------------------------------
    // control register and pin mute latch
    // ------------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            lat_q <= `AMZ_RST_LATENCY;
            zero_en_q <= 1'b0;
            clr_sel_q <= 1'b0;
            sw_mute_q <= 1'b0;
            clr_mute_q <= 1'b0;
            pin_mute_q <= 1'b0;
            pin_lvl_q <= 1'b0;
        end
        else
        begin
            pin_lvl_q <= pin_lvl;
            if (wr && hit_ctrl)
            begin
                // reserved bits are ignored on write
                lat_q <= i_pwdata[`AMZ_F_LAT_HI:`AMZ_F_LAT_LO];
                zero_en_q <= i_pwdata[`AMZ_F_ZERO_EN];
                clr_sel_q <= i_pwdata[`AMZ_F_CLR_SEL];
                sw_mute_q <= i_pwdata[`AMZ_F_SW_MUTE];
            end
            // writing 0 leaves the clear bit alone
            if (wr && hit_ctrl && i_pwdata[`AMZ_F_CLR_MUTE])
                clr_mute_q <= 1'b1;
            else if (clr_mute_q)
                clr_mute_q <= 1'b0; // self clears on the next clock
            // pin mute latch; a new pin assertion wins over any release
            // a pin still held low re-arms the latch, so a clear write then is lost
            if (pin_fall || pin_lvl)
                pin_mute_q <= 1'b1;
            else if (!clr_sel_q && pin_rise)
                pin_mute_q <= 1'b0;
            else if (clr_sel_q && clr_mute_q)
                pin_mute_q <= 1'b0; // only the clear bit releases
        end
    end

    // ------------------------------------------------------------------
    // mute state machine with ramp and zeroing latency
    // ------------------------------------------------------------------
    // the ramp stands in for the audio soft mute; latency starts when muted
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_q <= ST_RUN;
            ramp_q <= 7'h00;
            step_q <= 32'h0000_0000;
            lat_cnt_q <= 8'h00;
            zeroed_q <= 1'b0;
        end
        else
        begin
            case (st_q)
                ST_RUN:
                begin
                    zeroed_q <= 1'b0;
                    ramp_q <= 7'h00;
                    if (mute_req)
                        st_q <= ST_MUTING;
                end
                ST_MUTING:
                begin
                    if (!mute_req)
                    begin
                        st_q <= ST_UNMUTING;
                        ramp_q <= 7'h00;
                    end
                    else if (ramp_q == `AMZ_RAMP_CYC - 1)
                    begin
                        st_q <= ST_MUTED;
                        step_q <= 32'h0000_0000;
                        lat_cnt_q <= 8'h00;
                    end
                    else
                        ramp_q <= ramp_q + 7'h01;
                end
                ST_MUTED:
                begin
                    if (!mute_req)
                    begin
                        st_q <= ST_UNMUTING;
                        ramp_q <= 7'h00;
                    end
                    else if (zero_en_q && !zeroed_q)
                    begin
                        // code n waits n+1 steps of 1.066 ms
                        // a 32-bit step count keeps the full range at the core clock
                        if (step_q == STEP_CYC - 1)
                        begin
                            step_q <= 32'h0000_0000;
                            if (lat_cnt_q == lat_q)
                                zeroed_q <= 1'b1;
                            else
                                lat_cnt_q <= lat_cnt_q + 8'h01;
                        end
                        else
                            step_q <= step_q + 32'h0000_0001;
                    end
                    else if (!zero_en_q)
                        zeroed_q <= 1'b0; // not zeroed after mute
                end
                ST_UNMUTING:
                begin
                    zeroed_q <= 1'b0;
                    if (mute_req)
                    begin
                        st_q <= ST_MUTING;
                        ramp_q <= 7'h00;
                    end
                    else if (ramp_q == `AMZ_RAMP_CYC - 1)
                        st_q <= ST_RUN;
                    else
                        ramp_q <= ramp_q + 7'h01;
                end
                // an unused code falls back to running audio
                default:
                    st_q <= ST_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // idle square wave and pwm output selection
    // ------------------------------------------------------------------
    // a half-duty square keeps the amplifier biased with no audio
    // the square runs free, so a fresh mute joins it at whatever phase it holds
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sq_cnt_q <= 5'h00;
            sq_q <= 1'b0;
            o_amp_out <= {NCH{1'b0}};
            o_muted <= 1'b0;
        end
        else
        begin
            if (sq_cnt_q == `AMZ_SQ_HALF - 1)
            begin
                sq_cnt_q <= 5'h00;
                sq_q <= ~sq_q;
            end
            else
                sq_cnt_q <= sq_cnt_q + 5'h01;
            o_muted <= (st_q == ST_MUTED);
            if (zeroed_q)
                o_amp_out <= {NCH{1'b0}};
            else if (st_q == ST_MUTED)
                o_amp_out <= {NCH{sq_q}};
            else
                o_amp_out <= i_pwm_audio;
        end
    end

    // ------------------------------------------------------------------
    // per channel enable status
    // ------------------------------------------------------------------
    // all channels share one zeroing decision, so their bits move together
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : g_ch
            // set on leaving zero for the square wave or for audio, cleared when zeroed
            always @(posedge i_clk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    ch_en_q[g] <= 1'b0;
                    prev_zero_q[g] <= 1'b1;
                end
                else
                begin
                    prev_zero_q[g] <= zeroed_q;
                    if (zeroed_q)
                        ch_en_q[g] <= 1'b0;
                    else if (prev_zero_q[g])
                        ch_en_q[g] <= 1'b1;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // apb read path and ready
    // ------------------------------------------------------------------
    // ready rises in the access cycle, so each transfer has no wait state
    // read data is captured in the setup cycle and stands while pready is high
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
        else
        begin
            o_pready <= i_psel & ~i_penable;
            o_pslverr <= i_psel & ~i_penable & ~(hit_ctrl | hit_stat);
            if (i_psel && !i_penable && hit_ctrl)
                o_prdata <= {16'h0000, lat_q, 2'b00, zero_en_q, clr_sel_q,
                    sw_mute_q, clr_mute_q, mute_stat, mute_flag};
            else if (i_psel && !i_penable && hit_stat)
                o_prdata <= {{(32 - NCH){1'b0}}, ch_en_q};
            else if (rd)
                o_prdata <= o_prdata;
            else
                o_prdata <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// [testbench/amz_mute_chk_assertions.sv]
// port-level checker for the audio mute block
`timescale 1ns/1ps
`default_nettype none
`include "amz_defines.vh"
module amz_mute_chk
#(
    parameter NCH = 4
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // apb
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // pin and pwm stage
    input wire logic i_mute_pin_n,
    input wire logic [NCH-1:0] i_pwm_audio,
    input wire logic [NCH-1:0] o_amp_out,
    input wire logic o_muted
);
    logic [7:0] unm_q;
    logic rd_ctl;
    logic rd_st;
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    // unmuted run length, so a flag that skips the ramp is caught
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            unm_q <= 8'h00;
        else if (o_muted)
            unm_q <= 8'h00;
        else if (unm_q != 8'hFF)
            unm_q <= unm_q + 8'h01;
    end
    assign rd_ctl = o_pready && !i_pwrite && i_paddr == `AMZ_ADDR_MUTE_CTRL;
    assign rd_st = o_pready && !i_pwrite && i_paddr == `AMZ_ADDR_PWM_STAT;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_access;
        i_psel && i_penable && o_pready;
    endsequence
    AST_RDY: assert property (s_setup |=> s_access)
        else $error("no ready after setup");
    AST_RDY_ONE: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    AST_ERR: assert property (o_pready |-> o_pslverr == !(i_paddr == `AMZ_ADDR_MUTE_CTRL
        || i_paddr == `AMZ_ADDR_PWM_STAT))
        else $error("slave error wrong");
    AST_PASS: assert property (!$past(i_rst) && !o_muted && !$past(o_muted)
        && !$past(o_muted, 2) |-> o_amp_out == $past(i_pwm_audio))
        else $error("audio not passed while unmuted");
    AST_SQ: assert property (o_muted && $past(o_muted)
        |-> o_amp_out == '0 || o_amp_out == '1)
        else $error("muted output neither square nor zero");
    AST_RAMP: assert property ($rose(o_muted) |-> unm_q >= 8'h3F)
        else $error("muted flag before ramp end");
    AST_FLAG: assert property (rd_ctl |-> o_prdata[31:16] == 16'h0000
        && (!o_prdata[0] || o_prdata[1]))
        else $error("mute flag without status");
    AST_PWMST: assert property (rd_st |-> o_prdata[31:4] == 28'h0)
        else $error("pwm status upper bits set");
endmodule
bind amz_mute_ctrl amz_mute_chk #(.NCH(NCH)) i_amz_mute_chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_mute_pin_n(i_mute_pin_n), .i_pwm_audio(i_pwm_audio), .o_amp_out(o_amp_out),
    .o_muted(o_muted));
`default_nettype wire

// [testbench/amz_amp_model.sv]
// model of the pwm amplifier stage feeding the block its audio
`timescale 1ns/1ps
`default_nettype none
module amz_amp_model
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // pwm stage
    input wire logic [3:0] i_amp_out,
    output var logic [3:0] o_pwm_audio
);
    // odd step walks all codes, so a stuck output shows
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_pwm_audio <= 4'h6;
        else
            o_pwm_audio <= o_pwm_audio + 4'h7;
    end
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for the audio mute block
`timescale 1ns/1ps
`default_nettype none
`include "amz_defines.vh"
module testbench;
    logic clk, rst, psel, pen, pwr, pin_n, pready, perr, muted, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, seed;
    logic [3:0] aud, amp;
    logic [7:0] lat;
    int fails, cmp_count, hi;
    amz_mute_ctrl #(.NCH(4), .STEP_CYC(4)) i_amz_mute_ctrl (.i_clk(clk), .i_rst(rst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr), .i_mute_pin_n(pin_n),
        .i_pwm_audio(aud), .o_amp_out(amp), .o_muted(muted));
    amz_amp_model i_amz_amp_model (.i_clk(clk), .i_rst(rst), .i_amp_out(amp),
        .o_pwm_audio(aud));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        cmp_count++;
        if (g !== x)
        begin
            fails++;
            $display("Error t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    // one apb transfer; waits for ready under a bound
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            fails++;
            finish_test;
        end
        r = prdata;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task wait_m(input logic v);
        int n;
        n = 0;
        while (muted !== v && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 400)
        begin
            fails++;
            finish_test;
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {rst, psel, pen, pwr, paddr, pwdata, pin_n} = {4'h8, 12'h000, 32'h0, 1'b1};
        {fails, cmp_count, seed} = {32'd0, 32'd0, 32'h93DC9DE5};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        apb(0, `AMZ_ADDR_MUTE_CTRL, 0); chk(r, {16'h0000, `AMZ_RST_MUTE_CTRL});
        repeat (4)
        begin
            seed = lfsr(seed);
            apb(1, `AMZ_ADDR_PWM_STAT, {28'h0, seed[3:0]});
            apb(0, `AMZ_ADDR_PWM_STAT, 0); chk(r, 32'hF);
            apb(0, {4'h1, seed[7:2], 2'b00}, 0); chk({31'h0, e}, 32'h1);
            chk(r, 32'h0);
        end
        $display("register test done");
        // software mute; status leads the flag by the ramp
        apb(1, `AMZ_ADDR_MUTE_CTRL, 32'h8); apb(0, `AMZ_ADDR_MUTE_CTRL, 0); chk(r, 32'hA);
        wait_m(1); apb(0, `AMZ_ADDR_MUTE_CTRL, 0); chk(r, 32'hB);
        hi = 0;
        repeat (40) @(posedge clk) hi += (amp === 4'hF);
        chk(hi >= 16 && hi <= 24, 1);
        apb(1, `AMZ_ADDR_MUTE_CTRL, 0); wait_m(0); apb(0, `AMZ_ADDR_MUTE_CTRL, 0); chk(r, 0);
        $display("software mute test done");
        // zeroing after a random latency code
        seed = lfsr(seed);
        lat = {6'h0, seed[1:0]} + 8'h02;
        apb(1, `AMZ_ADDR_MUTE_CTRL, {16'h0, lat, 8'h28}); wait_m(1);
        repeat (lat * 4 - 4) @(posedge clk);
        apb(0, `AMZ_ADDR_PWM_STAT, 0); chk(r, 32'hF);
        repeat ((lat + 1) * 4 + 8) @(posedge clk);
        chk(amp, 0);
        apb(0, `AMZ_ADDR_PWM_STAT, 0); chk(r, 0);
        apb(1, `AMZ_ADDR_MUTE_CTRL, 0); wait_m(0); repeat (4) @(posedge clk);
        apb(0, `AMZ_ADDR_PWM_STAT, 0); chk(r, 32'hF);
        $display("zeroing test done");
        // pin mute under both clear selections
        for (int s = 0; s < 2; s++)
        begin
            apb(1, `AMZ_ADDR_MUTE_CTRL, 32'h10 * s);
            pin_n <= 1'b0; wait_m(1);
            apb(0, `AMZ_ADDR_MUTE_CTRL, 0); chk(r, 32'h10 * s + 3);
            pin_n <= 1'b1;
            if (s == 0)
                wait_m(0);
            else
            begin
                repeat (100) @(posedge clk);
                chk(muted, 1);
                apb(1, `AMZ_ADDR_MUTE_CTRL, 32'h14); wait_m(0);
                apb(0, `AMZ_ADDR_MUTE_CTRL, 0); chk(r, 32'h10);
            end
        end
        $display("pin mute test done");
        finish_test;
    end
endmodule
`default_nettype wire
